//--- hdl/occ_pkg.sv
// constants for the operator console control block
// assumes a single 125 mhz clock and an axi4-lite register master
package occ_pkg;
   localparam int D5_W = 20;
   localparam int D12_W = 48;
   localparam int BTN_N = 5;
   localparam int ALERT_N = 10;
   localparam int TRACE_N = 9;
   localparam int SENSE_N = 10;
   localparam int ILK_N = 7;
   localparam int EV_N = 5;
   localparam int DIAL_W = 16;
   localparam int ADDR_W = 8;
   // event bits
   localparam int EV_KBD = 0;
   localparam int EV_FORCE = 1;
   localparam int EV_ALERT = 2;
   localparam int EV_STORE = 3;
   localparam int EV_HALT = 4;
   // register byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CLEAR = 8'h04;
   localparam logic [7:0] OFS_ENABLE = 8'h08;
   localparam logic [7:0] OFS_CTRL = 8'h0c;
   localparam logic [7:0] OFS_DISP5 = 8'h10;
   localparam logic [7:0] OFS_DISP12_LO = 8'h14;
   localparam logic [7:0] OFS_DISP12_HI = 8'h18;
   localparam logic [7:0] OFS_RUN = 8'h1c;
   localparam logic [7:0] OFS_ALERT = 8'h20;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam logic [4:0] ENABLE_RST = 5'h00;
   localparam int CTRL_KBD_EN = 0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {RUN_HALT, RUN_CONT, RUN_STEP, RUN_DIAL}
      occ_run_t;
endpackage

//--- hdl/occ_console.sv
// operator console control: display registers, keyboard, buttons,
// run modes, initial load, indicators and an axi4-lite register slave
// assumes all inputs synchronous to aclk and buttons held as levels
`timescale 1ns/1ps
`default_nettype none
module occ_console
   import occ_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic irq,
   input wire logic kbd_valid,
   input wire logic kbd_sel12,
   input wire logic [3:0] kbd_digit,
   output logic [D5_W-1:0] disp5,
   output logic [D12_W-1:0] disp12,
   input wire logic cmp_dr_wr,
   input wire logic cmp_dr_sel12,
   input wire logic [D12_W-1:0] cmp_dr_wdata,
   input wire logic prc_dr_wr,
   input wire logic prc_dr_sel12,
   input wire logic [D12_W-1:0] prc_dr_wdata,
   input wire logic [BTN_N-1:0] cmp_btn,
   output logic cmp_force,
   output logic [2:0] cmp_vector,
   input wire logic [BTN_N-1:0] prc_btn,
   input wire logic [BTN_N-1:0] peer_prc_btn,
   input wire logic [ALERT_N-1:0] prc_ack,
   output logic [ALERT_N-1:0] prc_alert,
   input wire logic prn_valid,
   input wire logic [7:0] prn_char,
   output logic prn_strobe,
   output logic [7:0] prn_data,
   input wire logic load_btn,
   input wire logic load_end,
   input wire logic tape_valid,
   input wire logic [D12_W-1:0] tape_word,
   output logic tape_ready,
   output logic store_req,
   output logic [15:0] store_addr,
   input wire logic store_ack,
   input wire logic start_btn,
   input wire logic stop_btn,
   input wire logic cont_btn,
   input wire logic step_btn,
   input wire logic dial_btn,
   input wire logic [DIAL_W-1:0] dial_period,
   output logic cmp_go,
   input wire logic [D5_W-1:0] ctr_bcd,
   input wire logic [TRACE_N-1:0] trace_ff,
   input wire logic [SENSE_N-1:0] sense_ff,
   input wire logic [ILK_N-1:0] ilk_cond,
   output logic [D5_W-1:0] ind_ctr,
   output logic [TRACE_N-1:0] ind_trace,
   output logic [SENSE_N-1:0] ind_sense,
   output logic [ILK_N-1:0] ind_ilk
);
   ////////////////////////////////////////////////////////////////////////
   logic [BTN_N-1:0] cmp_btn_q, prc_btn_q, peer_btn_q, cmp_rise;
   logic [ALERT_N-1:0] alert_set;
   logic [4:0] run_btn_q;
   logic load_btn_q;
   logic [EV_N-1:0] status_q, status_d, enable_q, events;
   logic [31:0] ctrl_q;
   occ_run_t run_q, mode_q;
   logic [DIAL_W-1:0] dial_cnt_q;
   logic load_q;
   logic wr_fire;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [2:0] vec_enc;
   logic kbd_take;
   logic [31:0] rd_mux;
   logic rd_hit;

   assign cmp_rise = cmp_btn & ~cmp_btn_q;
   assign alert_set = {peer_prc_btn & ~peer_btn_q, prc_btn & ~prc_btn_q};
   assign kbd_take = kbd_valid && ctrl_q[CTRL_KBD_EN] && !load_q;
   assign wr_fire = !awready && !wready && !bvalid;

   always_comb
   begin
      vec_enc = 3'h0;
      for (int i = BTN_N - 1; i >= 0; i--)
      begin
         if (cmp_rise[i])
         begin
            vec_enc = 3'(i);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // button edge history
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cmp_btn_q <= '0;
         prc_btn_q <= '0;
         peer_btn_q <= '0;
         run_btn_q <= '0;
         load_btn_q <= 1'b0;
      end
      else
      begin
         cmp_btn_q <= cmp_btn;
         prc_btn_q <= prc_btn;
         peer_btn_q <= peer_prc_btn;
         run_btn_q <= {start_btn, stop_btn, cont_btn, step_btn, dial_btn};
         load_btn_q <= load_btn;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // display registers
   // panel display outputs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         disp5 <= '0;
         disp12 <= '0;
      end
      else if (cmp_dr_wr)
      begin
         if (cmp_dr_sel12)
            disp12 <= cmp_dr_wdata;
         else
            disp5 <= cmp_dr_wdata[D5_W-1:0];
      end
      else if (prc_dr_wr)
      begin
         if (prc_dr_sel12)
            disp12 <= prc_dr_wdata;
         else
            disp5 <= prc_dr_wdata[D5_W-1:0];
      end
      else if (tape_valid && tape_ready)
      begin
         disp12 <= tape_word;
      end
      else if (kbd_take)
      begin
         if (kbd_sel12)
            disp12 <= {disp12[D12_W-5:0], kbd_digit};
         else
            disp5 <= {disp5[D5_W-5:0], kbd_digit};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interventions
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cmp_force <= 1'b0;
         cmp_vector <= 3'h0;
      end
      else
      begin
         cmp_force <= |cmp_rise;
         if (|cmp_rise)
            cmp_vector <= vec_enc;
      end
   end

   generate
      for (genvar g = 0; g < ALERT_N; g++)
      begin : g_alert
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               prc_alert[g] <= 1'b0;
            else if (alert_set[g])
               prc_alert[g] <= 1'b1;
            else if (prc_ack[g])
               prc_alert[g] <= 1'b0;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // typewriter and indicators
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prn_strobe <= 1'b0;
         prn_data <= 8'h00;
         ind_ctr <= '0;
         ind_trace <= '0;
         ind_sense <= '0;
         ind_ilk <= '0;
      end
      else
      begin
         prn_strobe <= prn_valid;
         if (prn_valid)
            prn_data <= prn_char;
         ind_ctr <= ctr_bcd;
         ind_trace <= trace_ff;
         ind_sense <= sense_ff;
         ind_ilk <= ilk_cond;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // initial load from paper tape
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         load_q <= 1'b0;
         tape_ready <= 1'b0;
         store_req <= 1'b0;
         store_addr <= 16'h0000;
      end
      else if (load_end)
      begin
         load_q <= 1'b0;
         tape_ready <= 1'b0;
         store_req <= 1'b0;
      end
      else if (load_btn && !load_btn_q && !load_q)
      begin
         load_q <= 1'b1;
         tape_ready <= 1'b1;
         store_addr <= 16'h0000;
      end
      else if (tape_valid && tape_ready)
      begin
         tape_ready <= 1'b0;
         store_req <= 1'b1;
      end
      else if (store_req && store_ack)
      begin
         store_req <= 1'b0;
         tape_ready <= 1'b1;
         store_addr <= store_addr + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // run modes
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         run_q <= RUN_HALT;
         mode_q <= RUN_CONT;
         cmp_go <= 1'b0;
         dial_cnt_q <= '0;
      end
      else if (stop_btn && !run_btn_q[3])
      begin
         run_q <= RUN_HALT;
         cmp_go <= 1'b0;
      end
      else if (cont_btn && !run_btn_q[2])
      begin
         run_q <= RUN_CONT;
         mode_q <= RUN_CONT;
         cmp_go <= 1'b1;
      end
      else if (step_btn && !run_btn_q[1])
      begin
         run_q <= RUN_STEP;
         cmp_go <= 1'b0;
      end
      else if (dial_btn && !run_btn_q[0])
      begin
         run_q <= RUN_DIAL;
         mode_q <= RUN_DIAL;
         cmp_go <= 1'b0;
         dial_cnt_q <= '0;
      end
      else if (start_btn && !run_btn_q[4] && run_q == RUN_HALT)
      begin
         run_q <= mode_q;
         cmp_go <= 1'b0;
         dial_cnt_q <= '0;
      end
      else
      begin
         unique case (run_q)
            RUN_HALT:
               cmp_go <= 1'b0;
            RUN_CONT:
               cmp_go <= 1'b1;
            RUN_STEP:
            begin
               cmp_go <= 1'b1;
               run_q <= RUN_HALT;
            end
            RUN_DIAL:
            begin
               if (dial_cnt_q >= dial_period)
               begin
                  cmp_go <= 1'b1;
                  dial_cnt_q <= '0;
               end
               else
               begin
                  cmp_go <= 1'b0;
                  dial_cnt_q <= dial_cnt_q + DIAL_W'(1);
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt status, enable, control
   always_comb
   begin
      events = '0;
      events[EV_KBD] = kbd_take;
      events[EV_FORCE] = |cmp_rise;
      events[EV_ALERT] = |alert_set;
      events[EV_STORE] = store_req && store_ack;
      events[EV_HALT] = run_q != RUN_HALT && run_btn_q[3] == 1'b0
                        && stop_btn;
      status_d = status_q | events;
      if (wr_fire && aw_addr_q == OFS_CLEAR && w_strb_q[0])
         status_d = (status_q & ~w_data_q[EV_N-1:0]) | events;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         status_q <= '0;
         enable_q <= ENABLE_RST;
         ctrl_q <= CTRL_RST;
         irq <= 1'b0;
      end
      else
      begin
         status_q <= status_d;
         irq <= |(status_q & enable_q);
         if (wr_fire && aw_addr_q == OFS_ENABLE && w_strb_q[0])
            enable_q <= w_data_q[EV_N-1:0];
         if (wr_fire && aw_addr_q == OFS_CTRL && w_strb_q[0])
            ctrl_q <= {24'h000000, w_data_q[7:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite slave
   always_comb
   begin
      rd_hit = 1'b1;
      rd_mux = 32'h0000_0000;
      unique case (araddr)
         OFS_STATUS: rd_mux = {27'h0, status_q};
         OFS_ENABLE: rd_mux = {27'h0, enable_q};
         OFS_CTRL: rd_mux = ctrl_q;
         OFS_CLEAR: rd_mux = 32'h0000_0000;
         OFS_DISP5: rd_mux = {12'h000, disp5};
         OFS_DISP12_LO: rd_mux = disp12[31:0];
         OFS_DISP12_HI: rd_mux = {16'h0000, disp12[47:32]};
         OFS_RUN: rd_mux = {26'h0, load_q, cmp_go, mode_q, run_q};
         OFS_ALERT: rd_mux = {22'h0, prc_alert};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         aw_addr_q <= '0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_addr_q <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready)
         begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
            wready <= 1'b0;
         end
         if (wr_fire)
         begin
            bvalid <= 1'b1;
            if (aw_addr_q == OFS_CLEAR || aw_addr_q == OFS_ENABLE
                || aw_addr_q == OFS_CTRL)
               bresp <= RESP_OKAY;
            else
               bresp <= RESP_SLVERR;
         end
         if (bvalid && bready)
         begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_mux;
         rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid && rready)
      begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_kbd_shift;
      kbd_take && !kbd_sel12 && !cmp_dr_wr && !prc_dr_wr && !tape_ready
         |=> disp5 == {$past(disp5[D5_W-5:0]), $past(kbd_digit)};
   endproperty
   a_kbd_shift: assert property (p_kbd_shift)
      else $error("keyboard digit not shifted in");

   property p_cmp_write;
      cmp_dr_wr && cmp_dr_sel12 |=> disp12 == $past(cmp_dr_wdata);
   endproperty
   a_cmp_write: assert property (p_cmp_write)
      else $error("computer write to display lost");

   property p_force;
      |cmp_rise |=> cmp_force && cmp_vector == $past(vec_enc);
   endproperty
   a_force: assert property (p_force)
      else $error("intervention not forced");

   property p_alert_hold;
      prc_alert[0] && !prc_ack[0] |=> prc_alert[0];
   endproperty
   a_alert_hold: assert property (p_alert_hold)
      else $error("alert dropped without ack");

   property p_alert_set;
      alert_set[5] |=> prc_alert[5];
   endproperty
   a_alert_set: assert property (p_alert_set)
      else $error("peer console alert missed");

   property p_step;
      run_q == RUN_STEP && !stop_btn && !cont_btn && !dial_btn
         |=> cmp_go && run_q == RUN_HALT ##1 (!cmp_go || $past(cont_btn));
   endproperty
   a_step: assert property (p_step)
      else $error("single step not exactly one");

   property p_cont;
      run_q == RUN_CONT && !stop_btn && !step_btn && !dial_btn
         |=> cmp_go;
   endproperty
   a_cont: assert property (p_cont)
      else $error("continuous run stalled");

   property p_load;
      tape_valid && tape_ready && !load_end && !cmp_dr_wr && !prc_dr_wr
         |=> store_req && disp12 == $past(tape_word);
   endproperty
   a_load: assert property (p_load)
      else $error("tape word not staged to storage");

   property p_lamps;
      ##1 ind_trace == $past(trace_ff) && ind_ilk == $past(ilk_cond)
         && ind_sense == $past(sense_ff);
   endproperty
   a_lamps: assert property (p_lamps)
      else $error("indicator lamps stale");

   c_step: cover property (run_q == RUN_STEP ##1 cmp_go);
   c_force: cover property (cmp_force);
   c_load: cover property (store_req && store_ack);
   c_irq: cover property (irq);
endmodule
`default_nettype wire

//--- hdl/occ_dummy_none.sv
// intentionally empty helper: none
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- sim/occ_far_model.sv
// far side model: tape reader, main storage and processor program
// assumes occ_console samples its handshakes on the rising aclk edge
`timescale 1ns/1ps
`default_nettype none
module occ_far_model
   import occ_pkg::*;
#(
   parameter int ACK_DLY = 20
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic tape_ready,
   output logic tape_valid,
   output logic [D12_W-1:0] tape_word,
   input wire logic store_req,
   input wire logic [15:0] store_addr,
   output logic store_ack,
   input wire logic [ALERT_N-1:0] prc_alert,
   output logic [ALERT_N-1:0] prc_ack
);
   int k;
   int w;
   int a;
   logic [D12_W-1:0] word;
   ////////////////////////////////////////////////////////////////////
   // tape word source
   assign word = 48'h000000000100 + 48'(k);
   assign tape_word = tape_valid ? word : ~word;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tape_valid <= 1'b0;
         k <= 0;
      end
      else
      begin
         tape_valid <= 1'b1;
         if (tape_valid && tape_ready)
            k <= k + 1;
      end
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !store_req || store_ack)
      begin
         store_ack <= 1'b0;
         w <= 0;
      end
      else if (w >= (store_addr[0] ? 5 : 0))
         store_ack <= 1'b1;
      else
         w <= w + 1;
   end
   ////////////////////////////////////////////////////////////////////
   // deferred program ack
   always_ff @(posedge aclk)
   begin
      if (!aresetn || prc_alert == '0)
      begin
         prc_ack <= '0;
         a <= 0;
      end
      else if (a == ACK_DLY)
      begin
         prc_ack <= prc_alert;
         a <= 0;
      end
      else
      begin
         prc_ack <= '0;
         a <= a + 1;
      end
   end
endmodule
`default_nettype wire

//--- sim/occ_console_bench.sv
// self-checking bench for occ_console over axi4-lite and panel pins
// assumes occ_far_model on the tape, storage and alert side
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end
`define WT(c) begin for (n = 0; n < 60 && !(c); n++) @(posedge aclk); \
if (!(c)) begin err_count++; wrap_up(); end end
module occ_console_bench
   import occ_pkg::*;
;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq, kbd_valid, kbd_sel12;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb, kbd_digit;
   logic [1:0] bresp, rresp, rsp;
   logic [D5_W-1:0] disp5, ctr_bcd, ind_ctr;
   logic [D12_W-1:0] disp12, cmp_dr_wdata, prc_dr_wdata, tape_word;
   logic cmp_dr_wr, cmp_dr_sel12, prc_dr_wr, prc_dr_sel12, cmp_force;
   logic [BTN_N-1:0] cmp_btn, prc_btn, peer_prc_btn;
   logic [2:0] cmp_vector;
   logic [ALERT_N-1:0] prc_ack, prc_alert;
   logic prn_valid, prn_strobe, load_btn, load_end, tape_valid, tape_ready;
   logic [7:0] prn_char, prn_data;
   logic store_req, store_ack;
   logic [15:0] store_addr;
   logic start_btn, stop_btn, cont_btn, step_btn, dial_btn, cmp_go;
   logic [DIAL_W-1:0] dial_period;
   logic [TRACE_N-1:0] trace_ff, ind_trace;
   logic [SENSE_N-1:0] sense_ff, ind_sense;
   logic [ILK_N-1:0] ilk_cond, ind_ilk;
   int err_count, checks, n, k;
   occ_console dut_u (.*);
   occ_far_model far_u (.*);
   ////////////////////////////////////////////////////////////////////
   task wrap_up();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 60; n++)
      begin
         @(posedge aclk);
         if (awvalid === 1'b1 && awready === 1'b1)
            awvalid <= 1'b0;
         if (wvalid === 1'b1 && wready === 1'b1)
            wvalid <= 1'b0;
         if (bvalid === 1'b1)
            break;
      end
      if (n == 60)
      begin
         err_count++;
         wrap_up();
      end
      rsp = bresp;
      bready <= 1'b0;
   endtask
   task axr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 60; n++)
      begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
         if (rvalid === 1'b1)
            break;
      end
      if (n == 60)
      begin
         err_count++;
         wrap_up();
      end
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   task key(input logic [3:0] d);
      @(posedge aclk);
      kbd_valid <= 1'b1;
      kbd_digit <= d;
      @(posedge aclk);
      kbd_valid <= 1'b0;
   endtask
   task gocnt(input int c);
      k = 0;
      repeat (c)
      begin
         @(posedge aclk);
         if (cmp_go === 1'b1)
            k++;
      end
   endtask
   task press(input int b);
      @(posedge aclk);
      {stop_btn, cont_btn, step_btn, dial_btn} <= 4'(1 << b);
      @(posedge aclk);
      {stop_btn, cont_btn, step_btn, dial_btn} <= 4'h0;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   initial
   begin
      repeat (100000) @(posedge aclk);
      err_count++;
      wrap_up();
   end
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {kbd_valid, kbd_sel12, kbd_digit, cmp_dr_wr, cmp_dr_sel12} = '0;
      {cmp_dr_wdata, prc_dr_wr, prc_dr_sel12, prc_dr_wdata} = '0;
      {cmp_btn, prc_btn, peer_prc_btn, prn_valid, prn_char} = '0;
      {load_btn, load_end, start_btn, stop_btn, cont_btn} = '0;
      {step_btn, dial_btn, dial_period, ctr_bcd} = '0;
      {trace_ff, sense_ff, ilk_cond} = '0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      wstrb <= 4'hf;
      axr(OFS_CTRL);
      `CHK(rd, CTRL_RST)
      axr(8'h3c);
      `CHK(rsp, RESP_SLVERR)
      axw(OFS_STATUS, 32'h1f);
      `CHK(rsp, RESP_SLVERR)
      for (int i = 1; i <= 5; i++)
         key(4'(i));
      kbd_sel12 <= 1'b1;
      for (int i = 1; i <= 12; i++)
         key(4'(i % 10));
      repeat (2) @(posedge aclk);
      `CHK(disp5, 20'h12345)
      `CHK(disp12, 48'h123456789012)
      axr(OFS_DISP5);
      `CHK(rd, 32'h00012345)
      axr(OFS_DISP12_LO);
      `CHK(rd, 32'h56789012)
      axr(OFS_DISP12_HI);
      `CHK(rd, 32'h00001234)
      axr(OFS_STATUS);
      `CHK(rd, 32'h00000001)
      axw(OFS_ENABLE, 32'h1);
      repeat (3) @(posedge aclk);
      `CHK(irq, 1'b1)
      axw(OFS_ENABLE, 32'h0);
      repeat (3) @(posedge aclk);
      `CHK(irq, 1'b0)
      axw(OFS_CLEAR, 32'h1f);
      axr(OFS_STATUS);
      `CHK(rd, 32'h0)
      axw(OFS_CTRL, 32'h0);
      key(4'h7);
      repeat (2) @(posedge aclk);
      `CHK(disp12, 48'h123456789012)
      axw(OFS_CTRL, 32'h1);
      $display("test keyboard finished");
      @(posedge aclk);
      {cmp_dr_wr, prc_dr_wr, cmp_dr_sel12, prc_dr_sel12} <= 4'hf;
      cmp_dr_wdata <= 48'h111122223333;
      prc_dr_wdata <= 48'h999988887777;
      @(posedge aclk);
      {cmp_dr_wr, prc_dr_sel12} <= 2'h0;
      prc_dr_wdata <= 48'h000000054321;
      @(posedge aclk);
      prc_dr_wr <= 1'b0;
      repeat (2) @(posedge aclk);
      `CHK(disp12, 48'h111122223333)
      `CHK(disp5, 20'h54321)
      $display("test display finished");
      for (int i = 0; i < 5; i++)
      begin
         @(posedge aclk);
         cmp_btn <= 5'(1 << i);
         `WT(cmp_force === 1'b1)
         `CHK(cmp_vector, 3'(i))
         @(posedge aclk);
         `CHK(cmp_force, 1'b0)
         cmp_btn <= '0;
      end
      axr(OFS_STATUS);
      `CHK(rd[EV_FORCE], 1'b1)
      for (int i = 0; i < 10; i++)
      begin
         @(posedge aclk);
         {peer_prc_btn, prc_btn} <= 10'(1 << i);
         `WT(prc_alert[i] === 1'b1)
         `CHK(prc_alert, 10'(1 << i))
         {peer_prc_btn, prc_btn} <= '0;
         repeat (5) @(posedge aclk);
         `CHK(prc_alert[i], 1'b1)
         `WT(prc_alert[i] === 1'b0)
         `CHK(prc_alert, 10'h0)
      end
      $display("test buttons finished");
      @(posedge aclk);
      prn_char <= 8'ha5;
      prn_valid <= 1'b1;
      @(posedge aclk);
      prn_valid <= 1'b0;
      `WT(prn_strobe === 1'b1)
      `CHK(prn_data, 8'ha5)
      @(posedge aclk);
      `CHK(prn_strobe, 1'b0)
      @(posedge aclk);
      load_btn <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         `WT(store_req === 1'b1)
         `CHK(store_addr, 16'(i))
         `CHK(disp12, 48'h100 + 48'(i))
         `WT(store_req === 1'b0)
      end
      load_end <= 1'b1;
      load_btn <= 1'b0;
      @(posedge aclk);
      load_end <= 1'b0;
      repeat (3) @(posedge aclk);
      `CHK({tape_ready, store_req}, 2'h0)
      $display("test load finished");
      press(2);
      `WT(cmp_go === 1'b1)
      gocnt(8);
      `CHK(k, 8)
      press(3);
      repeat (3) @(posedge aclk);
      gocnt(20);
      `CHK(k, 0)
      axr(OFS_STATUS);
      `CHK(rd[EV_HALT], 1'b1)
      for (int i = 0; i < 2; i++)
      begin
         press(1);
         gocnt(20);
         `CHK(k, 1)
      end
      dial_period <= 16'd3;
      press(0);
      `WT(cmp_go === 1'b1)
      gocnt(40);
      `CHK(k, 10)
      press(3);
      @(posedge aclk);
      start_btn <= 1'b1;
      @(posedge aclk);
      start_btn <= 1'b0;
      `WT(cmp_go === 1'b1)
      gocnt(40);
      `CHK(k, 10)
      press(3);
      axr(OFS_RUN);
      `CHK(rd, 32'h0000000c)
      $display("test run finished");
      ctr_bcd <= 20'h98765;
      trace_ff <= 9'h155;
      sense_ff <= 10'h2aa;
      ilk_cond <= 7'h5a;
      repeat (3) @(posedge aclk);
      `CHK(ind_ctr, 20'h98765)
      `CHK(ind_trace, 9'h155)
      `CHK(ind_sense, 10'h2aa)
      `CHK(ind_ilk, 7'h5a)
      $display("test indicators finished");
      wrap_up();
   end
endmodule
`default_nettype wire
